//--- dv/meter_model.sv
// Model of the external meter on the two handshake lines
`timescale 1ns/1ps
module meter_model (
    input  wire       mclk,
    input  wire       enable,
    input  wire [3:0] lag,
    input  wire       closedOe,
    output wire       advanceIn
);
    reg       closedOld_r = 1'b0;
    reg [4:0] cnt_r = 5'h00;
    assign advanceIn = !(enable && cnt_r != 5'h00 && cnt_r < 5'h04);
    always @(posedge mclk) begin
        closedOld_r <= closedOe;
        if (enable && closedOld_r && !closedOe)
            cnt_r <= {1'b0, lag} + 5'h04;
        else if (cnt_r != 5'h00)
            cnt_r <= cnt_r - 5'h01;
    end
endmodule // meter_model

//--- dv/mux_scan_advance_control_tb.sv
// Testbench for the scan advance control block
`timescale 1ns/1ps
module mux_scan_advance_control_tb;
    localparam [15:0] LST = 16'hFB72;
    reg        mclk = 1'b0;
    reg        rst_n, vm, fw, cont, dl, meterEn;
    reg  [1:0] src;
    reg  [2:0] irqSel;
    reg  [3:0] wrIdx, wrChan, lastIdx, dChan, qChan;
    reg  [7:0] pls, passCnt, addrSw;
    wire       closure, advanceIn, closedOe, addressValid, scanBusy;
    wire [7:1] irqOe;
    wire [7:0] logicalAddress;
    wire [15:0] chanClosed;
    wire [3:0] scanPos;
    integer    err_total = 0, check_count = 0, cyc = 0, i, t = 0;
    mux_scan_advance_control dut (
        .mclk(mclk), .rst_n(rst_n), .trigger_source_select(src),
        .voltmeterMode(vm), .fourWireMode(fw),
        .continuous_scan_enable(cont), .scan_pass_count(passCnt),
        .listDownloaded(dl), .listWrEn(pls[7]), .listWrIdx(wrIdx),
        .listWrChan(wrChan), .listLastIdx(lastIdx), .scanStart(pls[0]),
        .scanAbort(pls[1]), .hostTrigger(pls[2]), .eventInTrigger(pls[3]),
        .directClose(pls[4]), .directOpenAll(pls[5]), .directChan(dChan),
        .queryChan(qChan), .closure_state_query(closure),
        .advanceIn(advanceIn), .closedOut(), .closedOe(closedOe),
        .irqLineSelect(irqSel), .irqAck(pls[6]), .irqOut(), .irqOe(irqOe),
        .logical_address_switch(addrSw), .logicalAddress(logicalAddress),
        .addressValid(addressValid), .chanClosed(chanClosed),
        .scanBusy(scanBusy), .scanPos(scanPos)
    );
    meter_model meter (.mclk(mclk), .enable(meterEn), .lag(4'h2),
        .closedOe(closedOe), .advanceIn(advanceIn));
    always #4 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////////////
    task stop_test;
        begin
            $display("checks %0d errors %0d", check_count, err_total);
            if (err_total == 0 && check_count > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            err_total = err_total + 1;
            stop_test;
        end
    end
    task chk(input [16:0] got, input [16:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("ERROR %0t got %h want %h", $time, got, exp);
            end
        end
    endtask
    task tick(input integer n);
        begin
            repeat (n) @(posedge mclk);
            #1;
        end
    endtask
    task go(input [2:0] k);
        begin
            pls = 8'h01 << k;
            tick(1);
            pls = 8'h00;
            tick(1);
        end
    endtask
    task endt;
        begin
            t = t + 1;
            $display("test %0d done", t);
        end
    endtask
    task waitq;
        integer n, m;
        begin
            for (n = 0; n < 60 && closedOe !== 1'b1; n = n + 1) tick(1);
            for (m = 0; m < 60 && closedOe !== 1'b0; m = m + 1) tick(1);
            chk({15'h0000, n < 60 && m < 60}, 16'h0001);
        end
    endtask
    function [15:0] ent(input integer k);
        ent = 16'h0001 << LST[(k % 4) * 4 +: 4];
    endfunction
    task scan(input integer n);
        integer k;
        begin
            go(0);
            for (k = 0; k < n; k = k + 1) begin
                waitq;
                chk(chanClosed, ent(k));
            end
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, pls, vm, fw, cont, dl, meterEn, wrIdx, wrChan, dChan} = 0;
        {src, lastIdx, passCnt, irqSel} = {2'h1, 4'h3, 8'h03, 3'h3};
        {addrSw, qChan} = {8'h70, 4'h5};
        tick(5);
        rst_n = 1'b1;
        tick(2);
        chk(logicalAddress, 16'h0070);
        addrSw = 8'h00;
        tick(3);
        chk(addressValid, 16'h0000);
        addrSw = 8'hFF;
        tick(3);
        chk({logicalAddress, addressValid}, 16'h01FF);
        endt;
        dChan = 4'h5;
        go(4);
        tick(24);
        chk({closure, chanClosed}, 17'h10020);
        dChan = 4'h9;
        go(4);
        tick(24);
        chk({closure, chanClosed}, 17'h00200);
        fw = 1'b1;
        dChan = 4'h3;
        go(4);
        tick(24);
        chk(chanClosed, 16'h0208);
        go(5);
        fw = 1'b0;
        tick(24);
        chk(chanClosed, 16'h0000);
        endt;
        for (i = 0; i < 4; i = i + 1) begin
            wrIdx = i[3:0];
            wrChan = LST[i * 4 +: 4];
            go(7);
        end
        {dl, meterEn} = 2'b11;
        scan(4);
        tick(40);
        chk({scanBusy, irqOe}, {1'b0, 7'h04});
        go(6);
        tick(2);
        chk(irqOe, 16'h0000);
        endt;
        {cont, irqSel} = {1'b1, 3'h7};
        scan(6);
        meterEn = 1'b0;
        chk({scanBusy, irqOe}, {1'b1, 7'h40});
        go(1);
        go(6);
        tick(24);
        chk({scanBusy, chanClosed}, 17'h00000);
        endt;
        {src, cont} = {2'h0, 1'b0};
        scan(1);
        go(2);
        waitq;
        chk(chanClosed, ent(1));
        go(3);
        waitq;
        chk(chanClosed, ent(2));
        vm = 1'b1;
        go(2);
        tick(40);
        chk(chanClosed, ent(2));
        {src, vm} = {2'h1, 1'b0};
        go(3);
        tick(40);
        chk(chanClosed, ent(2));
        endt;
        {dl, src, passCnt} = {1'b0, 2'h2, 8'h02};
        go(0);
        tick(200);
        chk(scanBusy, 16'h0001);
        tick(100);
        chk({scanBusy, irqOe}, 16'h0000);
        dl = 1'b1;
        go(0);
        tick(160);
        chk({scanBusy, irqOe}, {1'b0, 7'h40});
        src = 2'h0;
        scan(1);
        go(2);
        waitq;
        chk(chanClosed, ent(1));
        endt;
        rst_n = 1'b0;
        tick(5);
        rst_n = 1'b1;
        tick(1);
        chk({scanBusy, scanPos, irqOe}, 16'h0000);
        chk(chanClosed, 16'h0000);
        endt;
        stop_test;
    end
endmodule // mux_scan_advance_control_tb

//--- dv/mux_scan_chk.sv
// Assertion checker for the scan advance control block
`timescale 1ns/1ps
module mux_scan_chk (
    input wire        mclk,
    input wire        rst_n,
    input wire        fourWireMode,
    input wire [3:0]  queryChan,
    input wire        closure_state_query,
    input wire        closedOut,
    input wire        closedOe,
    input wire [7:1]  irqOut,
    input wire [7:1]  irqOe,
    input wire [7:0]  logicalAddress,
    input wire        addressValid,
    input wire [15:0] chanClosed,
    input wire        scanBusy,
    input wire [3:0]  scanPos
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    one_closed_a:
    assert property (!fourWireMode |-> $onehot0(chanClosed))
        else $error("two channels closed");
    break_make_a:
    assert property (!fourWireMode && $past(chanClosed) != 16'h0000
        && chanClosed != 16'h0000 |-> chanClosed == $past(chanClosed))
        else $error("channel changed without break");
    closed_pulse_a:
    assert property ($rose(closedOe) |-> closedOe[*8] ##[1:6] !closedOe)
        else $error("closed pulse length wrong");
    irq_line_a:
    assert property ($onehot0(irqOe))
        else $error("more than one irq line");
    open_coll_a:
    assert property (closedOut == 1'b0 && irqOut == 7'h00)
        else $error("open collector drives high");
    query_a:
    assert property (closure_state_query == chanClosed[queryChan])
        else $error("query disagrees with closure");
    addr_valid_a:
    assert property (addressValid == (logicalAddress != 8'h00))
        else $error("address valid flag wrong");
    reset_state_a:
    assert property ($rose(rst_n) |-> chanClosed == 16'h0000 && !scanBusy
        && irqOe == 7'h00 && scanPos == 4'h0)
        else $error("state not cleared by reset");
endmodule // mux_scan_chk
bind mux_scan_advance_control mux_scan_chk chk (
    .mclk(mclk), .rst_n(rst_n), .fourWireMode(fourWireMode),
    .queryChan(queryChan), .closure_state_query(closure_state_query),
    .closedOut(closedOut), .closedOe(closedOe), .irqOut(irqOut),
    .irqOe(irqOe), .logicalAddress(logicalAddress),
    .addressValid(addressValid), .chanClosed(chanClosed),
    .scanBusy(scanBusy), .scanPos(scanPos)
);

//--- verilog/edge_pulse_sync.v
// Two-flop synchroniser with falling-edge pulse detect
`timescale 1ns/1ps
module edge_pulse_sync (
    input  wire mclk,
    input  wire rst_n,
    input  wire pinIn,
    output reg  fallPulse
);
    reg stage1_r;
    reg stage2_r;
    reg stage3_r;

    always @(posedge mclk) begin
        if (!rst_n) begin
            stage1_r  <= 1'b1;
            stage2_r  <= 1'b1;
            stage3_r  <= 1'b1;
            fallPulse <= 1'b0;
        end else begin
            stage1_r  <= pinIn;
            stage2_r  <= stage1_r;
            stage3_r  <= stage2_r;
            fallPulse <= stage3_r & ~stage2_r;
        end
    end
endmodule // edge_pulse_sync

//--- verilog/mux_scan_advance_control.v
// Scan sequencing and channel closure control for a 16-channel mux card
//
// Contract
// - Digital-bus stepping uses exactly two handshake lines, one each way.
// - Advance line is an input starting a step; closed line reports completion.
// - Triggers come from backplane commands/event input or the handshake input; the code also has an immediate source that triggers every cycle.
// - In scanning-voltmeter mode only handshake advances step the channel.
// - Pass count is ignored when the list is downloaded locally.
// - Continuous scanning wraps from last entry back to first without stopping.
// - Handshake trigger source steps channels only on advance inputs.
// - Reaching the end of a downloaded list raises a backplane interrupt.
// - Interrupt drives the one selected line, valid selections 1 to 7.
// - Logical address from a switch, valid 1 to 255, default 112.
// - Closure query answers 1 for closed, 0 for open.
// - Break before make; at most one closed channel except four-wire mode.
// - Start closes first list channel; later triggers advance the list.
// - Handshake lines are open-collector TTL pulses driven by their owner.
`timescale 1ns/1ps
`include "mux_scan_defines.vh"
module mux_scan_advance_control (
    input  wire                 mclk,
    input  wire                 rst_n,
    input  wire [1:0]           trigger_source_select,
    input  wire                 voltmeterMode,
    input  wire                 fourWireMode,
    input  wire                 continuous_scan_enable,
    input  wire [7:0]           scan_pass_count,
    input  wire                 listDownloaded,
    input  wire                 listWrEn,
    input  wire [`LIST_W-1:0]   listWrIdx,
    input  wire [`CHAN_W-1:0]   listWrChan,
    input  wire [`LIST_W-1:0]   listLastIdx,
    input  wire                 scanStart,
    input  wire                 scanAbort,
    input  wire                 hostTrigger,
    input  wire                 eventInTrigger,
    input  wire                 directClose,
    input  wire                 directOpenAll,
    input  wire [`CHAN_W-1:0]   directChan,
    input  wire [`CHAN_W-1:0]   queryChan,
    output wire                 closure_state_query,
    input  wire                 advanceIn,
    output wire                 closedOut,
    output wire                 closedOe,
    input  wire [2:0]           irqLineSelect,
    input  wire                 irqAck,
    output wire [7:1]           irqOut,
    output wire [7:1]           irqOe,
    input  wire [7:0]           logical_address_switch,
    output reg  [7:0]           logicalAddress,
    output wire                 addressValid,
    output reg  [`CHAN_COUNT-1:0] chanClosed,
    output reg                  scanBusy,
    output reg  [`LIST_W-1:0]   scanPos
);
    ////////////////////////////////////////////////////////////////////////
    // Functions
    function [`CHAN_COUNT-1:0] chanMask;
        input [`CHAN_W-1:0] ch;
        begin
            chanMask = {{(`CHAN_COUNT-1){1'b0}}, 1'b1} << ch;
        end
    endfunction

    function [`LIST_W-1:0] nextPos;
        input [`LIST_W-1:0] pos;
        begin
            nextPos = pos + {{(`LIST_W-1){1'b0}}, 1'b1};
        end
    endfunction

    localparam [1:0] ST_IDLE   = 2'h0;
    localparam [1:0] ST_BREAK  = 2'h1;
    localparam [1:0] ST_SETTLE = 2'h2;
    localparam [1:0] ST_PULSE  = 2'h3;
    // Counter end points
    localparam [31:0] BREAK_W  = `BREAK_CYC;
    localparam [31:0] SETTLE_W = `SETTLE_CYC;
    localparam [31:0] PULSE_W  = `CLOSED_PULSE_CYC;

    localparam [`CNT_W-1:0] BREAK_N  = BREAK_W[`CNT_W-1:0];
    localparam [`CNT_W-1:0] SETTLE_N = SETTLE_W[`CNT_W-1:0];
    localparam [`CNT_W-1:0] PULSE_N  = PULSE_W[`CNT_W-1:0];

    reg [1:0]             state_r;
    reg [1:0]             state_nxt;
    reg [`CNT_W-1:0]      cnt_r;
    reg [`CHAN_W-1:0]     target_r;
    reg                   targetHold_r;
    reg                   fromScan_r;
    reg                   closedDrv_r;
    reg                   irqPend_r;
    reg [2:0]             irqLine_r;
    reg [7:0]             passLeft_r;
    wire                  advPulse;
    wire [`CHAN_W-1:0]    listChan;
    wire                  srcTrig;
    wire                  atLast;
    reg [`LIST_W-1:0]     rdIdx;

    ////////////////////////////////////////////////////////////////////////
    // Handshake input and list storage
    // one line each way
    edge_pulse_sync advSync (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .pinIn     (advanceIn),
        .fallPulse (advPulse)
    );

    scan_list_ram listRam (
        .mclk   (mclk),
        .wrEn   (listWrEn),
        .wrIdx  (listWrIdx),
        .wrData (listWrChan),
        .rdIdx  (rdIdx),
        .rdData (listChan)
    );

    ////////////////////////////////////////////////////////////////////////
    // Trigger selection
    // voltmeter uses handshake only
    assign srcTrig = voltmeterMode ? advPulse :
        (trigger_source_select == `SRC_HANDSHAKE) ? advPulse :
        (trigger_source_select == `SRC_BACKPLANE) ?
            (hostTrigger | eventInTrigger) :
        (trigger_source_select == `SRC_IMMEDIATE);
    assign atLast = (scanPos == listLastIdx);

    // Look-ahead list read
    always @* begin
        rdIdx = scanPos;
        if (!scanBusy || scanStart) begin
            rdIdx = {`LIST_W{1'b0}};
        end else if (!atLast) begin
            rdIdx = nextPos(scanPos);
        end else begin
            rdIdx = {`LIST_W{1'b0}};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Step sequencer
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (scanStart || directClose ||
                    (scanBusy && srcTrig)) begin
                    state_nxt = ST_BREAK;
                end
            end
            ST_BREAK: begin
                if (cnt_r == BREAK_N) begin
                    state_nxt = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                if (cnt_r == SETTLE_N) begin
                    state_nxt = fromScan_r ? ST_PULSE : ST_IDLE;
                end
            end
            ST_PULSE: begin
                if (cnt_r == PULSE_N) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always @(posedge mclk) begin
        if (!rst_n) begin
            state_r      <= ST_IDLE;
            cnt_r        <= {`CNT_W{1'b0}};
            target_r     <= {`CHAN_W{1'b0}};
            targetHold_r <= 1'b0;
            fromScan_r   <= 1'b0;
            closedDrv_r  <= 1'b0;
            chanClosed   <= {`CHAN_COUNT{1'b0}};
            scanBusy     <= 1'b0;
            scanPos      <= {`LIST_W{1'b0}};
            passLeft_r   <= 8'h00;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= (state_nxt != state_r) ? {`CNT_W{1'b0}} :
                       cnt_r + {{(`CNT_W-1){1'b0}}, 1'b1};
            closedDrv_r <= (state_nxt == ST_PULSE);
            if (scanAbort || directOpenAll) begin
                scanBusy   <= 1'b0;
                chanClosed <= {`CHAN_COUNT{1'b0}};
            end
            if (state_r == ST_IDLE && state_nxt == ST_BREAK) begin
                targetHold_r <= fourWireMode;
                if (scanStart) begin
                    scanBusy   <= 1'b1;
                    scanPos    <= {`LIST_W{1'b0}};
                    target_r   <= listChan;
                    fromScan_r <= 1'b1;
                    passLeft_r <= listDownloaded ? 8'h00 :
                                  scan_pass_count;
                end else if (directClose) begin
                    target_r   <= directChan;
                    fromScan_r <= 1'b0;
                end else begin
                    target_r   <= listChan;
                    fromScan_r <= 1'b1;
                    if (!atLast) begin
                        scanPos <= nextPos(scanPos);
                    end else begin
                        scanPos <= {`LIST_W{1'b0}};
                        if (!continuous_scan_enable && listDownloaded) begin
                            scanBusy <= 1'b0;
                        end else if (!continuous_scan_enable) begin
                            if (passLeft_r <= 8'h01) begin
                                scanBusy <= 1'b0;
                            end
                            passLeft_r <= passLeft_r - 8'h01;
                        end
                    end
                end
            end
            if (state_r == ST_BREAK && cnt_r == {`CNT_W{1'b0}} &&
                !targetHold_r) begin
                chanClosed <= {`CHAN_COUNT{1'b0}};
            end
            if (state_r == ST_BREAK && state_nxt == ST_SETTLE) begin
                chanClosed <= (targetHold_r ? chanClosed :
                              {`CHAN_COUNT{1'b0}}) | chanMask(target_r);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Handshake output, open collector
    // closed reports completion
    assign closedOut = 1'b0;
    assign closedOe  = closedDrv_r;

    ////////////////////////////////////////////////////////////////////////
    // Query and address
    // closure query
    assign closure_state_query = chanClosed[queryChan];

    always @(posedge mclk) begin
        if (!rst_n) begin
            logicalAddress <= `LOGICAL_ADDRESS_SWITCH_DEFAULT;
        end else begin
            logicalAddress <= logical_address_switch;
        end
    end
    assign addressValid = (logicalAddress >= `LOGICAL_ADDRESS_SWITCH_MIN);

    ////////////////////////////////////////////////////////////////////////
    // Interrupt request
    always @(posedge mclk) begin
        if (!rst_n) begin
            irqPend_r <= 1'b0;
            irqLine_r <= `IRQ_LINE_MAX;
        end else begin
            if ((irqLineSelect >= `IRQ_LINE_MIN) &&
                (irqLineSelect <= `IRQ_LINE_MAX)) begin
                irqLine_r <= irqLineSelect;
            end
            if (listDownloaded && scanBusy && atLast &&
                state_r == ST_IDLE && state_nxt == ST_BREAK &&
                !scanStart && !directClose) begin
                irqPend_r <= 1'b1;
            end else if (irqAck) begin
                irqPend_r <= 1'b0;
            end
        end
    end

    genvar g;
    generate
        for (g = 1; g <= 7; g = g + 1) begin : irqDrv
            assign irqOut[g] = 1'b0;
            assign irqOe[g]  = irqPend_r && (irqLine_r == g);
        end
    endgenerate
endmodule // mux_scan_advance_control

//--- verilog/mux_scan_defines.vh
// Constants for the scan advance control block
`ifndef MUX_SCAN_DEFINES_VH
`define MUX_SCAN_DEFINES_VH
`define CHAN_COUNT        16
`define CHAN_W            4
`define LIST_DEPTH        16
`define LIST_W            4
`define SRC_BACKPLANE     2'h0
`define SRC_HANDSHAKE     2'h1
`define SRC_IMMEDIATE     2'h2
`define LOGICAL_ADDRESS_SWITCH_DEFAULT     8'h70
`define LOGICAL_ADDRESS_SWITCH_MIN         8'h01
`define IRQ_LINE_MIN      3'h1
`define IRQ_LINE_MAX      3'h7
`define BREAK_NS          40
`define SETTLE_NS         80
`define CLK_NS            8
`define BREAK_CYC         ((`BREAK_NS + `CLK_NS - 1) / `CLK_NS)
`define SETTLE_CYC        ((`SETTLE_NS + `CLK_NS - 1) / `CLK_NS)
`define CLOSED_PULSE_NS   80
`define CLOSED_PULSE_CYC  ((`CLOSED_PULSE_NS + `CLK_NS - 1) / `CLK_NS)
`define CNT_W             4
`endif

//--- verilog/scan_list_ram.v
// Flip-flop storage for the downloaded scan list
`timescale 1ns/1ps
`include "mux_scan_defines.vh"
module scan_list_ram (
    input  wire                 mclk,
    input  wire                 wrEn,
    input  wire [`LIST_W-1:0]   wrIdx,
    input  wire [`CHAN_W-1:0]   wrData,
    input  wire [`LIST_W-1:0]   rdIdx,
    output wire [`CHAN_W-1:0]   rdData
);
    reg [`CHAN_W-1:0] mem [0:`LIST_DEPTH-1];

    always @(posedge mclk) begin
        if (wrEn) begin
            mem[wrIdx] <= wrData;
        end
    end

    assign rdData = mem[rdIdx];
endmodule // scan_list_ram
